// ---- rtl/ftpc_consts.vh ----
`ifndef FTPC_CONSTS_VH
`define FTPC_CONSTS_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define FTPC_IDX_ONE_SELECT 8'h56
`define FTPC_IDX_TWO_SELECT 8'h57
`define FTPC_IDX_CONTROL 8'h58
`define FTPC_IDX_ONE_COUNT 8'h59

// ****************************************
// Control field positions
// ****************************************
`define FTPC_ONE_SRC_BIT 0
`define FTPC_TWO_SRC_BIT 1
`define FTPC_ONE_MULT_BIT 2
`define FTPC_TWO_MULT_BIT 3
`define FTPC_ONE_DIV_LSB 4
`define FTPC_ONE_DIV_MSB 5
`define FTPC_TWO_DIV_LSB 6
`define FTPC_TWO_DIV_MSB 7
`define FTPC_CLK_SELECT_BIT 7

// ****************************************
// Reset values
// ****************************************
`define FTPC_CONTROL_RST 8'h50
`define FTPC_COUNT_RST 8'h00
`define FTPC_SELECT_RST 1'h0
`define FTPC_COUNT_MAX 8'hFF

// ****************************************
// Bus responses
// ****************************************
`define FTPC_RESP_OKAY 2'h0
`define FTPC_RESP_SLVERR 2'h2

`endif

// ---- rtl/ftpc_tach_counter.v ----
`timescale 1ns/1ps
`default_nettype none

module ftpc_tach_counter #(
    parameter PW = 16
) (
    input wire clock,
    input wire rst_b,
    input wire [PW-1:0] tickPeriod,
    input wire tachIn,
    output reg [7:0] count
);

`include "ftpc_consts.vh"

reg [PW-1:0] tickCnt;
reg [7:0] runCount;
reg tachPrev;
wire tick;
wire pulseEdge;

// A period shortened mid-count still ends at once thanks to the >= test
assign tick = (tickCnt >= tickPeriod - {{(PW-1){1'b0}}, 1'b1});
assign pulseEdge = tachIn & ~tachPrev;

// ****************************************
// Counting clock and pulse period count
// ****************************************
always @(posedge clock) begin
    if (!rst_b) begin
        tickCnt <= {PW{1'b0}};
        runCount <= `FTPC_COUNT_RST;
        tachPrev <= 1'b0;
        count <= `FTPC_COUNT_RST;
    end else begin
        tachPrev <= tachIn;
        if (tick || pulseEdge) begin
            tickCnt <= {PW{1'b0}};
        end else begin
            tickCnt <= tickCnt + {{(PW-1){1'b0}}, 1'b1};
        end
        // R9: latch at pulse end
        if (pulseEdge) begin
            count <= runCount;
            runCount <= `FTPC_COUNT_RST;
        end else if (tick && runCount != `FTPC_COUNT_MAX) begin
            // R8: count ticks per pulse
            runCount <= runCount + 8'h01;
        end
    end
end

endmodule

`default_nettype wire

// ---- rtl/ftpc_top.v ----
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R1: Fan one counting clock from control bit 0, multiplier, and select bit 7.
// R2: Fan two counting clock from control bit 1, multiplier, and select bit 7.
// R3: Control bit 2 set doubles the fan one counting rate.
// R4: Control bit 3 set doubles the fan two counting rate.
// R5: Bits 5:4 divide fan one count by 1,2,4,8; reset code divide by 2.
// R6: Bits 7:6 divide fan two count by 1,2,4,8; reset code divide by 2.
// R7: Control register resets to 0x50 and is host read/write.
// R8: Fan one count holds 8-bit counting-clock cycles per fan pulse.
// R9: Count shows the latched final count of the previous pulse.
// R10: Counting clock rate per mode comes from configurable constants.
module ftpc_top #(
    parameter AW = 12,
    parameter PW = 16,
    parameter [PW-1:0] BASE_MODE0 = 16'h0400,
    parameter [PW-1:0] BASE_MODE1 = 16'h0200,
    parameter [PW-1:0] BASE_MODE2 = 16'h0100,
    parameter [PW-1:0] BASE_MODE3 = 16'h0080
) (
    input wire clock,
    input wire rst_b,
    input wire [AW-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [AW-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire fanOneTach,
    input wire fanTwoTach,
    output wire [7:0] fanTwoCount
);

`include "ftpc_consts.vh"

// ****************************************
// Register storage
// ****************************************
reg [7:0] fanClockControl;
reg fanOneSelect;
reg fanTwoSelect;
wire [7:0] fanOneTachCount;

reg awHeld;
reg wHeld;
reg [AW-1:0] awAddr;
reg [31:0] wData;
reg [3:0] wStrb;

wire [PW-1:0] fanOnePeriod;
wire [PW-1:0] fanTwoPeriod;

// ****************************************
// Helpers
// ****************************************
function [AW-1:0] byteAddr;
    input [7:0] idx;
    begin
        byteAddr = {{(AW-10){1'b0}}, idx, 2'b00};
    end
endfunction

// R10: per-mode rate constants
function [PW-1:0] periodOf;
    input src;
    input sel;
    input mult;
    input [1:0] div;
    reg [PW-1:0] base;
    begin
        case ({sel, src})
            2'h0: base = BASE_MODE0;
            2'h1: base = BASE_MODE1;
            2'h2: base = BASE_MODE2;
            default: base = BASE_MODE3;
        endcase
        // Halving the tick period doubles the counting rate
        if (mult) begin
            base = base >> 1;
        end
        // Dividing the count means stretching the tick period
        periodOf = base << div;
        if (periodOf == {PW{1'b0}}) begin
            periodOf = {{(PW-1){1'b0}}, 1'b1};
        end
    end
endfunction

// R1: fan one source and select
// R3: fan one multiplier
// R5: fan one divisor
assign fanOnePeriod = periodOf(fanClockControl[`FTPC_ONE_SRC_BIT], fanOneSelect,
    fanClockControl[`FTPC_ONE_MULT_BIT],
    fanClockControl[`FTPC_ONE_DIV_MSB:`FTPC_ONE_DIV_LSB]);

// R2: fan two source and select
// R4: fan two multiplier
// R6: fan two divisor
assign fanTwoPeriod = periodOf(fanClockControl[`FTPC_TWO_SRC_BIT], fanTwoSelect,
    fanClockControl[`FTPC_TWO_MULT_BIT],
    fanClockControl[`FTPC_TWO_DIV_MSB:`FTPC_TWO_DIV_LSB]);

// ****************************************
// Tachometer channels
// ****************************************
ftpc_tach_counter #(
    .PW(PW)
) fanOneCounter (
    .clock(clock),
    .rst_b(rst_b),
    .tickPeriod(fanOnePeriod),
    .tachIn(fanOneTach),
    .count(fanOneTachCount)
);

ftpc_tach_counter #(
    .PW(PW)
) fanTwoCounter (
    .clock(clock),
    .rst_b(rst_b),
    .tickPeriod(fanTwoPeriod),
    .tachIn(fanTwoTach),
    .count(fanTwoCount)
);

// ****************************************
// Write channel
// ****************************************
// Address and data are parked independently so either may arrive first
assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
assign s_axi_wready = ~wHeld & ~s_axi_bvalid;

wire doWrite;
wire writeHit;
assign doWrite = awHeld & wHeld;
assign writeHit = (awAddr == byteAddr(`FTPC_IDX_CONTROL)) ||
    (awAddr == byteAddr(`FTPC_IDX_ONE_SELECT)) ||
    (awAddr == byteAddr(`FTPC_IDX_TWO_SELECT));

always @(posedge clock) begin
    if (!rst_b) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        awAddr <= {AW{1'b0}};
        wData <= 32'h00000000;
        wStrb <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `FTPC_RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end
        if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? `FTPC_RESP_OKAY : `FTPC_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// R7: control reset and host writes
always @(posedge clock) begin
    if (!rst_b) begin
        fanClockControl <= `FTPC_CONTROL_RST;
        fanOneSelect <= `FTPC_SELECT_RST;
        fanTwoSelect <= `FTPC_SELECT_RST;
    end else if (doWrite && wStrb[0]) begin
        if (awAddr == byteAddr(`FTPC_IDX_CONTROL)) begin
            fanClockControl <= wData[7:0];
        end
        if (awAddr == byteAddr(`FTPC_IDX_ONE_SELECT)) begin
            fanOneSelect <= wData[`FTPC_CLK_SELECT_BIT];
        end
        if (awAddr == byteAddr(`FTPC_IDX_TWO_SELECT)) begin
            fanTwoSelect <= wData[`FTPC_CLK_SELECT_BIT];
        end
    end
end

// ****************************************
// Read channel
// ****************************************
assign s_axi_arready = ~s_axi_rvalid;

reg [31:0] next_rdata;
reg [1:0] next_rresp;

always @* begin
    next_rdata = 32'h00000000;
    next_rresp = `FTPC_RESP_OKAY;
    if (s_axi_araddr == byteAddr(`FTPC_IDX_CONTROL)) begin
        next_rdata = {24'h000000, fanClockControl};
    end else if (s_axi_araddr == byteAddr(`FTPC_IDX_ONE_COUNT)) begin
        // R9: latched count readback
        next_rdata = {24'h000000, fanOneTachCount};
    end else if (s_axi_araddr == byteAddr(`FTPC_IDX_ONE_SELECT)) begin
        next_rdata = {24'h000000, fanOneSelect, 7'h00};
    end else if (s_axi_araddr == byteAddr(`FTPC_IDX_TWO_SELECT)) begin
        next_rdata = {24'h000000, fanTwoSelect, 7'h00};
    end else begin
        next_rresp = `FTPC_RESP_SLVERR;
    end
end

always @(posedge clock) begin
    if (!rst_b) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `FTPC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

`default_nettype wire

// ---- verification/ftpc_fan_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Fan tach source; a zero period parks the line low during the register tests
module ftpc_fan_model (
    input wire logic clock,
    input wire logic [15:0] period,
    output wire logic tach
);
    logic [15:0] phase = 16'h0000;
    logic level = 1'h0;
    assign tach = level;
    always @(posedge clock) begin
        phase <= (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;
        level <= phase < (period >> 1);
    end
endmodule
`default_nettype wire

// ---- verification/ftpc_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ftpc_checker (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic fanTwoTach,
    input wire logic [7:0] fanTwoCount
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer: assert property (s_both_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer late");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_reset_idle: assert property (disable iff (1'h0)
        !rst_b |=> !s_axi_rvalid && fanTwoCount == 8'h00) else $error("busy after reset");
    // Count may only move in the cycle after the tach line was sampled high
    a_count_latched: assert property ($changed(fanTwoCount) |-> $past(fanTwoTach))
        else $error("count moved outside a pulse edge");
endmodule
bind ftpc_top ftpc_checker i_ftpc_checker (.*);
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] BASE [4] = '{16'h0008, 16'h0010, 16'h0020, 16'h0040};
    logic clock = 1'h0, rst_b = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [15:0] period = 16'h0000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fanOneTach;
    wire fanTwoTach;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] fanTwoCount;
    logic [33:0] readQ [$];
    logic [1:0] respQ [$];
    int failures = 0, nCompared = 0;
    assign fanTwoTach = fanOneTach;
    always #5 clock = ~clock;
    ftpc_top #(.BASE_MODE0(BASE[0]), .BASE_MODE1(BASE[1]), .BASE_MODE2(BASE[2]),
        .BASE_MODE3(BASE[3])) i_ftpc_top (.*);
    ftpc_fan_model i_ftpc_fan_model (.clock(clock), .period(period), .tach(fanOneTach));
    // ****************
    // Bus tasks
    // ****************
    task automatic check(input string what, input logic [33:0] exp, input logic [33:0] got);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Readies are read before the edge's own updates land, so no race
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] r);
        bit aw = 1'h1, w = 1'h1;
        respQ.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (aw || w) begin
            @(posedge clock);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge clock); while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [11:0] a, input logic [33:0] e);
        readQ.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge clock); while (!s_axi_rvalid);
    endtask
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready) begin
            check("read", readQ.pop_front(), {s_axi_rresp, s_axi_rdata});
        end
        if (s_axi_bvalid && s_axi_bready) begin
            check("bresp", {32'h0, respQ.pop_front()}, {32'h0, s_axi_bresp});
        end
    end
    task automatic print_verdict();
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        logic [31:0] v;
        int t;
        void'($urandom(28));
        repeat (8) @(posedge clock);
        rst_b <= 1'h1;
        rd(12'h160, 34'h50);
        rd(12'h164, 34'h0);
        rd(12'h16C, 34'h200000000);
        v = $urandom;
        wr(12'h16C, v, 4'hF, 2'h2);
        wr(12'h160, v, 4'hF, 2'h0);
        wr(12'h160, ~v, 4'h0, 2'h0);
        rd(12'h160, {26'h0, v[7:0]});
        $display("register tests done");
        for (int k = 0; k < 8; k++) begin
            t = (BASE[k[1:0]] >> k[2]) << k[1:0];
            wr(12'h158, {24'h0, k[1], 7'h0}, 4'hF, 2'h0);
            wr(12'h15C, {24'h0, k[1], 7'h0}, 4'hF, 2'h0);
            rd(12'h158, {26'h0, k[1], 7'h0});
            rd(12'h15C, {26'h0, k[1], 7'h0});
            wr(12'h160, {24'h0, k[1:0], k[1:0], k[2], k[2], k[0], k[0]}, 4'hF, 2'h0);
            // Half a tick of margin keeps the edge phase from mattering
            period <= 16'(3 * t + t / 2);
            repeat (14 * t) @(posedge clock);
            rd(12'h164, 34'h3);
            check("fan two count", 34'h3, {26'h0, fanTwoCount});
            $display("mode test %0d done", k);
        end
        wr(12'h160, 32'h0, 4'hF, 2'h0);
        period <= 16'h2328;
        repeat (27000) @(posedge clock);
        rd(12'h164, 34'hFF);
        $display("saturation test done");
        // Three reset edges keep the count drop inside the disabled window
        rst_b <= 1'h0;
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        rd(12'h160, 34'h50);
        rd(12'h164, 34'h0);
        $display("reset test done");
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
